// [sslc_pkg.sv]
// sslc_pkg: shared constants and types for the stack limit guard
// assumes a 16-bit byte-addressed data space with word-aligned stack
package sslc_pkg;

	// data address width and program counter width
	localparam int SSLC_AW = 16;
	localparam int SSLC_PCW = 24;

	// stack pointer value after reset
	localparam logic [15:0] SSLC_SP_RESET = 16'h0800;
	// lowest legal stack address; below it lies register space
	localparam logic [15:0] SSLC_SFR_TOP = 16'h0800;
	// one stack word in bytes
	localparam logic [15:0] SSLC_WORD_STEP = 16'h0002;
	// bit forced clear for word alignment
	localparam int SSLC_ALIGN_BIT = 0;
	// bit of the upper pushed word that holds the pc msb
	localparam int SSLC_PC_MSB_POS = 7;

	// stack operations requested by the core
	typedef enum logic [1:0]
	{
		SSLC_OP_PUSH = 2'h0,
		SSLC_OP_POP = 2'h1,
		SSLC_OP_CALL = 2'h2,
		SSLC_OP_EXC = 2'h3
	} sslc_op_e;

	// sequencer states
	typedef enum logic
	{
		SSLC_ST_IDLE = 1'h0,
		SSLC_ST_HIWORD = 1'h1
	} sslc_state_e;

endpackage : sslc_pkg

// [sslc_ea_if.sv]
// sslc_ea_if: effective address handed to the bounds checker
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface sslc_ea_if;
	logic valid;
	logic [15:0] ea;
	logic [15:0] limit;
	logic overflow;
	logic underflow;

	// the sequencer asks, the checker answers in the same cycle
	modport req (output valid, ea, limit, input overflow, underflow);
	modport chk (input valid, ea, limit, output overflow, underflow);
endinterface : sslc_ea_if

// [sslc_bound_check.sv]
// sslc_bound_check: combinational overflow and underflow compare
// assumes limit already has its low bit cleared by the owner
`timescale 1ns/1ps
module sslc_bound_check
	import sslc_pkg::*;
(
	// effective address to judge
	sslc_ea_if.chk ea_bus
);

	// unsigned compares, no sign games across the 0x8000 boundary
	always_comb
	begin
		ea_bus.overflow = ea_bus.valid && (ea_bus.ea > ea_bus.limit);
		ea_bus.underflow = ea_bus.valid && (ea_bus.ea < SSLC_SFR_TOP);
	end

endmodule : sslc_bound_check

// [sslc_stack_guard.sv]
// sslc_stack_guard: stack pointer, push/pop sequencing, limit trap
// assumes the core issues one stack op at a time and reads pop data
// itself from the memory at mem_addr
`timescale 1ns/1ps
module sslc_stack_guard
	import sslc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// working register and limit writes
	input wire logic sp_wr_en,
	input wire logic [15:0] sp_wr_data,
	input wire logic lim_wr_en,
	input wire logic [15:0] lim_wr_data,
	// stack operation request
	input wire logic op_valid,
	input wire sslc_op_e op_kind,
	input wire logic [15:0] op_data,
	input wire logic [SSLC_PCW-1:0] pc,
	input wire logic [7:0] status_low_byte,
	output logic op_ready,
	// other addressing through the stack pointer
	input wire logic ind_valid,
	input wire logic [15:0] ind_ea,
	// memory access
	output logic mem_req,
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	// state and traps
	output logic [15:0] stack_ptr,
	output logic stack_err_trap,
	output logic err_overflow,
	output logic err_underflow
);

	sslc_state_e state_q;
	logic [15:0] sp_q;
	logic [15:0] limit_q;
	logic [15:0] hi_word_q;
	logic [15:0] hi_word_d;
	logic [15:0] ea_cur;
	logic [15:0] wdata_cur;
	logic op_take;
	logic stack_move;
	logic is_pop;
	logic word_push;
	logic trap_now;

	sslc_ea_if ea_bus ();

	sslc_bound_check u_check
	(
		.ea_bus(ea_bus)
	);

	// one op at a time; pointer writes and other accesses hold ops off
	assign op_ready = (state_q == SSLC_ST_IDLE) && !sp_wr_en && !ind_valid;
	assign op_take = op_valid && op_ready;
	assign stack_move = op_take || (state_q == SSLC_ST_HIWORD);
	assign is_pop = op_take && (op_kind == SSLC_OP_POP);
	assign word_push = stack_move && !is_pop;

	// address and data of the current stack word
	always_comb
	begin
		ea_cur = sp_q;
		wdata_cur = op_data;
		if (state_q == SSLC_ST_HIWORD)
		begin
			wdata_cur = hi_word_q;
		end
		else if (is_pop)
		begin
			ea_cur = sp_q - SSLC_WORD_STEP;
		end
		else if (op_take && (op_kind != SSLC_OP_PUSH))
		begin
			wdata_cur = pc[15:0];
		end
		else if (!op_take && ind_valid)
		begin
			ea_cur = ind_ea;
		end
	end

	// upper pc word; call clears the msb, exception adds status byte
	always_comb
	begin
		if (op_kind == SSLC_OP_EXC)
		begin
			hi_word_d = {status_low_byte, pc[SSLC_PCW-1:16]};
		end
		else
		begin
			hi_word_d = {8'h00, 1'b0, pc[SSLC_PCW-2:16]};
		end
	end

	// every stack word address goes through the checker; an indirect address only while the sequencer is idle
	assign ea_bus.valid = stack_move || (ind_valid && state_q == SSLC_ST_IDLE);
	assign ea_bus.ea = ea_cur;
	assign ea_bus.limit = limit_q;
	assign trap_now = ea_bus.overflow || ea_bus.underflow;

	// limit has no reset on purpose; low bit tied clear
	// a limit write lands at the edge, so a stack read one op later
	// already sees it; the core keeps the gap itself
	always_ff @(posedge clk)
	begin
		if (lim_wr_en)
		begin
			limit_q <= {lim_wr_data[15:1], 1'b0};
		end
	end

	// stack pointer; a trapped access leaves it untouched
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sp_q <= SSLC_SP_RESET;
		end
		else if (sp_wr_en)
		begin
			sp_q <= {sp_wr_data[15:1], 1'b0};
		end
		else if (stack_move && !trap_now)
		begin
			if (is_pop)
			begin
				sp_q <= sp_q - SSLC_WORD_STEP;
			end
			else
			begin
				sp_q <= sp_q + SSLC_WORD_STEP;
			end
		end
	end

	// sequencer: pc pushes take two words, low word first
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_q <= SSLC_ST_IDLE;
		end
		else
		begin
			case (state_q)
				SSLC_ST_IDLE:
				begin
					if (op_take && !trap_now && op_kind[1])
					begin
						state_q <= SSLC_ST_HIWORD;
					end
				end
				SSLC_ST_HIWORD:
				begin
					state_q <= SSLC_ST_IDLE;
				end
				default:
				begin
					state_q <= SSLC_ST_IDLE;
				end
			endcase
		end
	end

	// upper word held for the second cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			hi_word_q <= 16'h0000;
		end
		else if (op_take)
		begin
			hi_word_q <= hi_word_d;
		end
	end

	// memory strobe; a trapping access never reaches memory
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 16'h0000;
		end
		else
		begin
			mem_req <= stack_move && !trap_now;
			mem_we <= word_push;
			mem_addr <= ea_cur;
			mem_wdata <= wdata_cur;
		end
	end

	// trap pulses, one cycle after the offending address
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			stack_err_trap <= 1'b0;
			err_overflow <= 1'b0;
			err_underflow <= 1'b0;
		end
		else
		begin
			stack_err_trap <= trap_now;
			err_overflow <= ea_bus.overflow;
			err_underflow <= ea_bus.underflow;
		end
	end

	assign stack_ptr = sp_q;

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_call_lo;
		op_take && op_kind == SSLC_OP_CALL && !trap_now;
	endsequence

	sequence s_exc_lo;
		op_take && op_kind == SSLC_OP_EXC && !trap_now;
	endsequence

	sequence s_hi_ok;
		state_q == SSLC_ST_HIWORD && !trap_now && !sp_wr_en;
	endsequence

	chk_push_next_free: assert property (
		mem_req && mem_we && !$past(sp_wr_en)
		|-> stack_ptr == mem_addr + SSLC_WORD_STEP)
		else $error("pointer not past pushed word");

	chk_pop_pre_dec: assert property (
		is_pop && !trap_now && !sp_wr_en
		|=> mem_req && !mem_we && stack_ptr == $past(sp_q) - SSLC_WORD_STEP
		&& mem_addr == stack_ptr)
		else $error("pop did not pre-decrement");

	chk_call_msb_clear: assert property (
		s_call_lo ##1 s_hi_ok
		|=> mem_req && mem_wdata[15:SSLC_PC_MSB_POS] == 9'h000)
		else $error("call upper word not zero-extended");

	chk_exc_status_join: assert property (
		s_exc_lo ##1 s_hi_ok
		|=> mem_req && mem_wdata[15:8] == $past(status_low_byte, 2)
		&& mem_wdata[7:0] == $past(pc[SSLC_PCW-1:16], 2))
		else $error("exception word lacks status byte");

	chk_limit_lsb_zero: assert property (
		lim_wr_en |=> limit_q == {$past(lim_wr_data[15:1]), 1'b0})
		else $error("limit write not aligned");

	chk_equal_no_trap: assert property (
		op_take && op_kind == SSLC_OP_PUSH && sp_q == limit_q
		&& sp_q >= SSLC_SFR_TOP |=> mem_req && !stack_err_trap)
		else $error("push at limit trapped");

	chk_over_trap: assert property (
		ea_bus.valid && ea_cur > limit_q
		|=> stack_err_trap && err_overflow && !mem_req)
		else $error("overflow not trapped");

	chk_under_trap: assert property (
		ea_bus.valid && ea_cur < SSLC_SFR_TOP
		|=> stack_err_trap && err_underflow && !mem_req)
		else $error("underflow not trapped");

endmodule : sslc_stack_guard

// [sslc_mem_model.sv]
// sslc_mem_model: core data memory facing the stack guard
// assumes one registered access pulse per stack word, same clock
`timescale 1ns/1ps
module sslc_mem_model
(
	// clock and access
	input wire logic clk,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata
);
	logic [15:0] mem [0:32767];

	// word store; bit 0 dropped since stack words are aligned
	always @(posedge clk)
		if (mem_req && mem_we)
			mem[mem_addr[15:1]] <= mem_wdata;
endmodule : sslc_mem_model

// [tb_top.sv]
// tb_top: directed scenarios for the stack guard
// assumes the memory model stands in for the core's data space
`timescale 1ns/1ps
module tb_top import sslc_pkg::*;;
	logic clk, reset, sp_wr_en, lim_wr_en, op_valid, ind_valid, op_ready;
	logic [15:0] sp_wr_data, lim_wr_data, op_data, ind_ea;
	sslc_op_e op_kind;
	logic [23:0] pc;
	logic [7:0] slb;
	logic mem_req, mem_we, trap, ovf, unf;
	logic [15:0] mem_addr, mem_wdata, stack_ptr;
	int bad_count, n_compared;

	sslc_stack_guard i_sslc_stack_guard (.clk(clk), .reset(reset),
		.sp_wr_en(sp_wr_en), .sp_wr_data(sp_wr_data),
		.lim_wr_en(lim_wr_en), .lim_wr_data(lim_wr_data),
		.op_valid(op_valid), .op_kind(op_kind), .op_data(op_data),
		.pc(pc), .status_low_byte(slb), .op_ready(op_ready),
		.ind_valid(ind_valid), .ind_ea(ind_ea), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.stack_ptr(stack_ptr), .stack_err_trap(trap),
		.err_overflow(ovf), .err_underflow(unf));
	sslc_mem_model i_sslc_mem_model (.clk(clk), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

	// free-running core clock
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	task results;
		if (bad_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	task chk(input string nm, input logic [15:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one-cycle write of limit (l=1) or pointer (l=0)
	task wr(input logic l, input logic [15:0] v);
		@(posedge clk);
		if (l)
		begin
			lim_wr_en <= 1;
			lim_wr_data <= v;
		end
		else
		begin
			sp_wr_en <= 1;
			sp_wr_data <= v;
		end
		@(posedge clk);
		lim_wr_en <= 0;
		sp_wr_en <= 0;
	endtask : wr

	// request held until taken; returns in the answer cycle
	task op(input sslc_op_e k, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		op_valid <= 1;
		op_kind <= k;
		op_data <= d;
		@(negedge clk);
		while (op_ready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				bad_count++;
				results;
			end
			@(negedge clk);
		end
		@(posedge clk);
		op_valid <= 0;
		@(negedge clk);
	endtask : op

	// trap, overflow, underflow, request as one nibble
	function automatic logic [15:0] flags();
		return {12'h000, trap, ovf, unf, mem_req};
	endfunction : flags

	task t_pushpop;
		chk("reset ptr", stack_ptr, SSLC_SP_RESET);
		wr(1, 16'hfffe);
		wr(0, 16'h0900);
		op(SSLC_OP_PUSH, 16'hbeef);
		chk("push we", {15'h0, mem_we}, 16'h0001);
		chk("push addr", mem_addr, 16'h0900);
		chk("push data", mem_wdata, 16'hbeef);
		chk("push ptr", stack_ptr, 16'h0902);
		op(SSLC_OP_POP, 16'h0000);
		chk("pop flags", flags(), 16'h0001);
		chk("pop addr", mem_addr, 16'h0900);
		chk("pop ptr", stack_ptr, 16'h0900);
	endtask : t_pushpop

	task t_call;
		wr(0, 16'h0a00);
		pc <= 24'hc12345;
		slb <= 8'ha5;
		op(SSLC_OP_CALL, 16'h0000);
		chk("call busy", {15'h0, op_ready}, 16'h0000);
		repeat (2) @(negedge clk);
		chk("call lo", i_sslc_mem_model.mem[16'h0500], 16'h2345);
		chk("call hi", i_sslc_mem_model.mem[16'h0501], 16'h0041);
		op(SSLC_OP_EXC, 16'h0000);
		repeat (2) @(negedge clk);
		chk("exc lo", i_sslc_mem_model.mem[16'h0502], 16'h2345);
		chk("exc hi", i_sslc_mem_model.mem[16'h0503], 16'ha5c1);
		chk("exc ptr", stack_ptr, 16'h0a08);
	endtask : t_call

	// limit just below the sign boundary catches a signed compare
	task t_limits;
		wr(1, 16'h7ffe);
		wr(0, 16'h7ffe);
		op(SSLC_OP_PUSH, 16'h0001);
		chk("at limit", flags(), 16'h0001);
		op(SSLC_OP_PUSH, 16'h0002);
		chk("past limit", flags(), 16'h000c);
		chk("trap ptr", stack_ptr, 16'h8000);
		wr(0, 16'h0800);
		op(SSLC_OP_POP, 16'h0000);
		chk("underflow", flags(), 16'h000a);
		chk("under ptr", stack_ptr, 16'h0800);
	endtask : t_limits

	// odd limit must act as the even value below it
	task t_ind(input logic [15:0] ea, exp);
		@(posedge clk);
		ind_valid <= 1;
		ind_ea <= ea;
		@(posedge clk);
		ind_valid <= 0;
		@(negedge clk);
		chk("indirect", flags(), exp);
	endtask : t_ind

	// stimulus and verdict
	initial
	begin
		reset = 1;
		{sp_wr_en, lim_wr_en, op_valid, ind_valid} = 4'h0;
		{sp_wr_data, lim_wr_data, op_data, ind_ea} = 64'h0;
		op_kind = SSLC_OP_PUSH;
		pc = 24'h000000;
		slb = 8'h00;
		repeat (4) @(posedge clk);
		reset <= 0;
		@(negedge clk);
		t_pushpop;
		t_call;
		t_limits;
		wr(1, 16'h1001);
		t_ind(16'h1001, 16'h000c);
		t_ind(16'h0700, 16'h000a);
		results;
	end
endmodule : tb_top
